//--- hw/cwb_pkg.sv
// constants, types and state layout for the channel word buffer and block move
package cwb_pkg;
  localparam int NCH = 6;
  localparam int AW  = 15;
  localparam int DW  = 48;

  typedef logic [AW-1:0] cwb_addr_t;
  typedef logic [DW-1:0] cwb_word_t;

  // control word layout in core: current address above, terminal address below
  localparam int CW_UP_LSB = 24;
  localparam int CW_LO_LSB = 0;
  localparam cwb_addr_t CW_LOC_FIRST = 15'h0001;
  localparam cwb_addr_t CW_LOC_LAST  = 15'h0006;

  // block move opcodes
  localparam logic [5:0] OP_MOVE_IN  = 6'h32;
  localparam logic [5:0] OP_MOVE_OUT = 6'h33;

  // apb byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STAT     = 12'h004;
  localparam logic [11:0] REG_CW_BASE  = 12'h010;
  localparam logic [11:0] REG_BM_BASE  = 12'h030;
  localparam logic [11:0] REG_BM_COUNT = 12'h034;
  localparam logic [11:0] REG_BM_CMD   = 12'h038;

  // field positions
  localparam int CWR_UP_LSB  = 16;
  localparam int CWR_LO_LSB  = 0;
  localparam int CTRL_ACT    = 0;
  localparam int CTRL_DIR    = 8;
  localparam int STAT_WAIT   = 0;
  localparam int STAT_ACK    = 8;
  localparam int STAT_SVC    = 16;
  localparam int STAT_DES    = 17;
  localparam int STAT_BUSY   = 20;
  localparam int STAT_HALTED = 21;
  localparam int STAT_NZ     = 22;
  localparam int STAT_INACT  = 23;
  localparam int STAT_DONE   = 24;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SVC  = 3'b010,
    ST_BM   = 3'b100
  } cwb_main_t;

  typedef enum logic [4:0] {
    BM_OFF       = 5'b00001,
    BM_IN_WAIT   = 5'b00010,
    BM_IN_HS     = 5'b00100,
    BM_OUT_FETCH = 5'b01000,
    BM_OUT_HS    = 5'b10000
  } cwb_bm_t;

  typedef struct packed {
    logic      req;
    logic      we;
    cwb_addr_t addr;
    cwb_word_t wdata;
  } cwb_mem_t;

  typedef struct packed {
    cwb_main_t                st;
    cwb_bm_t                  bm;
    logic [NCH-1:0][AW-1:0]   cw_up;
    logic [NCH-1:0][AW-1:0]   cw_lo;
    logic [NCH-1:0]           active;
    logic [NCH-1:0]           dir;
    logic [NCH-1:0]           wait_f;
    logic [NCH-1:0]           ack_f;
    logic [NCH-1:0]           in_res;
    logic [NCH-1:0][DW-1:0]   out_data;
    logic [NCH-1:0]           in_s1;
    logic [NCH-1:0]           in_s2;
    logic [NCH-1:0]           res_s1;
    logic [NCH-1:0]           res_s2;
    logic [2:0]               x_s1;
    logic [2:0]               x_s2;
    logic                     svc;
    logic [2:0]               des;
    logic [2:0]               ptr;
    cwb_addr_t                ccr_up;
    cwb_addr_t                ccr_lo;
    cwb_mem_t                 mem;
    logic                     busy;
    cwb_addr_t                bm_base;
    cwb_addr_t                bm_count;
    cwb_addr_t                r;
    cwb_addr_t                bm_addr;
    logic                     bm_in;
    logic                     nz;
    logic                     inact;
    logic                     done;
    logic                     halted;
    logic                     cpu_halt;
    logic                     x_res;
    logic                     x_rdy;
    logic                     x_got;
    cwb_word_t                x_data;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
  } cwb_state_t;
endpackage

//--- hw/cwb_top.sv
// channel word buffer service and channel 7 block move, with apb registers
// Overview of operation
// - service starts only when request flag set
// - busy storage, load control word, bump address
// - end word: fix wait flag, clear request
// - end buffer when current equals terminal address
// - output wait raises output word ready
// - resume: set ack, clear wait, drop ready
// - resume falls: clear ack, allow next request
// - input ready precedes service; output resume follows
// - control word locations also reach channel register
// - control word fields split between register, core
// - opcode 62 moves in, 63 moves out
// - block move halts processor, buffers continue
// - block moves use channel 7 only
// - count from index; descend from base+count-1
// - input waits ready; each ready stores word
// - input resume answers word, dropped after ready
// - write back count, flag nonzero, exit or wait
// - halt request blocks loop, count kept
// - first output immediate, later after resume cycle
// - present word, raise output ready, exit done
// - halted output adds two to saved count
// - scanner stops on pending channel, sets designator
//
// Added by the designer: the APB slave port and the placing of the registers.
module cwb_top (
  // clock and reset
  input  wire logic                                  SYS_CLK,
  input  wire logic                                  RESET,
  // apb slave
  input  wire logic                                  PSEL,
  input  wire logic                                  PENABLE,
  input  wire logic                                  PWRITE,
  input  wire logic [11:0]                           PADDR,
  input  wire logic [31:0]                           PWDATA,
  output logic      [31:0]                           PRDATA,
  output logic                                       PREADY,
  output logic                                       PSLVERR,
  // core storage port
  output cwb_pkg::cwb_mem_t                          MEM,
  input  wire cwb_pkg::cwb_word_t                    MEM_RDATA,
  input  wire logic                                  MEM_ACK,
  output logic                                       STORAGE_BUSY,
  // buffered channels 1 to 6
  input  wire logic [cwb_pkg::NCH-1:0]               IN_READY,
  input  wire logic [cwb_pkg::NCH-1:0][cwb_pkg::DW-1:0] IN_DATA,
  output logic      [cwb_pkg::NCH-1:0]               IN_RESUME,
  input  wire logic [cwb_pkg::NCH-1:0]               OUT_RESUME,
  output logic      [cwb_pkg::NCH-1:0]               OUT_READY,
  output logic      [cwb_pkg::NCH-1:0][cwb_pkg::DW-1:0] OUT_DATA,
  // channel 7 block move lines
  input  wire logic                                  XIN_READY,
  input  wire cwb_pkg::cwb_word_t                    XIN_DATA,
  output logic                                       XIN_RESUME,
  input  wire logic                                  XOUT_RESUME,
  output logic                                       XOUT_READY,
  output cwb_pkg::cwb_word_t                         XOUT_DATA,
  // processor side
  input  wire logic                                  INT_REQ,
  output logic                                       CPU_HALT,
  output logic                                       INPUT_MOVE_ACTIVE
);
  import cwb_pkg::*;

  cwb_state_t s;
  cwb_state_t n;

  always_comb begin
    logic [NCH-1:0] pend;
    logic           acc;
    logic           wr;
    logic           hit;
    logic [31:0]    rd;
    logic [2:0]     ch;
    logic [2:0]     tgt;
    logic           loc;
    cwb_addr_t      nxt;
    cwb_word_t      w;
    pend = '0;
    acc  = 1'b0;
    wr   = 1'b0;
    hit  = 1'b0;
    rd   = 32'h0;
    ch   = 3'h0;
    tgt  = 3'h0;
    loc  = 1'b0;
    nxt  = '0;
    w    = '0;
    n    = s;

    // two-stage synchronisers on the ready, resume and interrupt request lines
    n.in_s1  = IN_READY;
    n.in_s2  = s.in_s1;
    n.res_s1 = OUT_RESUME;
    n.res_s2 = s.res_s1;
    n.x_s1   = {INT_REQ, XOUT_RESUME, XIN_READY};
    n.x_s2   = s.x_s1;

    // apb: ready one cycle after setup, read data sampled at setup
    acc      = PSEL & PENABLE & s.pready;
    wr       = acc & PWRITE;
    n.pready = PSEL & ~PENABLE;
    unique case (PADDR)
      REG_CTRL: begin
        hit = 1'b1;
        rd[CTRL_ACT +: NCH] = s.active;
        rd[CTRL_DIR +: NCH] = s.dir;
      end
      REG_STAT: begin
        hit = 1'b1;
        rd[STAT_WAIT +: NCH] = s.wait_f;
        rd[STAT_ACK +: NCH]  = s.ack_f;
        rd[STAT_SVC]         = s.svc;
        rd[STAT_DES +: 3]    = s.des;
        rd[STAT_BUSY]        = s.cpu_halt;
        rd[STAT_HALTED]      = s.halted;
        rd[STAT_NZ]          = s.nz;
        rd[STAT_INACT]       = s.inact;
        rd[STAT_DONE]        = s.done;
      end
      REG_BM_BASE: begin
        hit = 1'b1;
        rd[AW-1:0] = s.bm_base;
      end
      REG_BM_COUNT: begin
        hit = 1'b1;
        rd[AW-1:0] = s.bm_count;
      end
      REG_BM_CMD: begin
        hit = 1'b1;
      end
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (PADDR == REG_CW_BASE + 12'(4 * i)) begin
            hit = 1'b1;
            rd[CWR_UP_LSB +: AW] = s.cw_up[i];
            rd[CWR_LO_LSB +: AW] = s.cw_lo[i];
          end
        end
      end
    endcase
    // read data is captured at setup so it stands through the access
    if (PSEL & ~PENABLE) begin
      n.prdata  = PWRITE ? 32'h0 : rd;
      n.pslverr = ~hit;
    end

    if (wr) begin
      unique case (PADDR)
        REG_CTRL: begin
          n.active = PWDATA[CTRL_ACT +: NCH];
          n.dir    = PWDATA[CTRL_DIR +: NCH];
        end
        REG_BM_BASE:  n.bm_base  = PWDATA[AW-1:0];
        REG_BM_COUNT: n.bm_count = PWDATA[AW-1:0];
        REG_BM_CMD: begin
          // refused while a move or its last handshake is still open
          if (s.bm == BM_OFF &&
              (PWDATA[5:0] == OP_MOVE_IN || PWDATA[5:0] == OP_MOVE_OUT)) begin
            n.halted = 1'b0;
            n.bm_in  = (PWDATA[5:0] == OP_MOVE_IN);
            if (s.bm_count == '0) begin
              n.done = 1'b1;
            end else begin
              n.done     = 1'b0;
              n.cpu_halt = 1'b1;
              n.r        = s.bm_count - 15'h1;
              n.bm_addr  = s.bm_base + s.bm_count - 15'h1;
              n.inact    = (PWDATA[5:0] == OP_MOVE_IN);
              n.bm       = (PWDATA[5:0] == OP_MOVE_IN) ? BM_IN_WAIT : BM_OUT_FETCH;
            end
          end
        end
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (PADDR == REG_CW_BASE + 12'(4 * i)) begin
              n.cw_up[i] = PWDATA[CWR_UP_LSB +: AW];
              n.cw_lo[i] = PWDATA[CWR_LO_LSB +: AW];
            end
          end
        end
      endcase
    end

    // per-channel ready/resume handshakes
    for (int i = 0; i < NCH; i++) begin
      if (s.dir[i]) begin
        if (s.wait_f[i] && s.res_s2[i]) begin
          n.ack_f[i]  = 1'b1;
          n.wait_f[i] = 1'b0;
        end else if (s.ack_f[i] && !s.res_s2[i]) begin
          n.ack_f[i]  = 1'b0;
        end
      end else if (s.in_res[i] && !s.in_s2[i]) begin
        n.in_res[i] = 1'b0;
      end
      // input needs ready first, output needs the previous word closed
      pend[i] = s.active[i] & (s.dir[i] ? (~s.wait_f[i] & ~s.ack_f[i])
                                        : (s.in_s2[i] & ~s.in_res[i]));
    end

    // request scanner walks channels until one is pending
    if (!s.svc) begin
      if (pend[s.ptr]) begin
        n.svc = 1'b1;
        n.des = s.ptr + 3'h1;
      end else begin
        n.ptr = (s.ptr == 3'(NCH - 1)) ? 3'h0 : s.ptr + 3'h1;
      end
    end

    // designator runs 1 to 6, the arrays index from 0
    ch  = s.des - 3'h1;
    loc = (s.ccr_up >= CW_LOC_FIRST) && (s.ccr_up <= CW_LOC_LAST);
    tgt = 3'(s.ccr_up - 15'h1);
    nxt = s.ccr_up + 15'h1;

    unique case (s.st)
      ST_IDLE: begin
        // buffered channels win storage over a running block move
        if (s.svc) begin
          n.busy      = 1'b1;
          n.ccr_up    = s.cw_up[ch];
          n.ccr_lo    = s.cw_lo[ch];
          n.mem.req   = 1'b1;
          n.mem.we    = ~s.dir[ch];
          n.mem.addr  = s.cw_up[ch];
          n.mem.wdata = IN_DATA[ch];
          n.st        = ST_SVC;
        end else if (s.bm == BM_IN_WAIT && s.x_s2[0]) begin
          if (s.x_s2[2]) begin
            // leave count and address as they are for the refetch
            n.bm       = BM_OFF;
            n.halted   = 1'b1;
            n.inact    = 1'b0;
            n.cpu_halt = 1'b0;
          end else begin
            n.inact     = 1'b0;
            n.mem.req   = 1'b1;
            n.mem.we    = 1'b1;
            n.mem.addr  = s.bm_addr;
            n.mem.wdata = XIN_DATA;
            n.st        = ST_BM;
          end
        end else if (s.bm == BM_OUT_FETCH) begin
          n.mem.req  = 1'b1;
          n.mem.we   = 1'b0;
          n.mem.addr = s.bm_addr;
          n.st       = ST_BM;
        end
      end
      ST_SVC: begin
        if (MEM_ACK) begin
          n.mem.req = 1'b0;
          n.busy    = 1'b0;
          if (s.dir[ch]) begin
            w = MEM_RDATA;
            // control word slots show the live channel registers, not stale core
            if (loc) begin
              w[CW_UP_LSB +: AW] = s.cw_up[tgt];
              w[CW_LO_LSB +: AW] = s.cw_lo[tgt];
            end
            n.out_data[ch] = w;
            n.wait_f[ch]   = 1'b1;
          end else begin
            if (loc) begin
              n.cw_up[tgt] = s.mem.wdata[CW_UP_LSB +: AW];
              n.cw_lo[tgt] = s.mem.wdata[CW_LO_LSB +: AW];
            end
            n.wait_f[ch] = 1'b0;
            n.in_res[ch] = 1'b1;
          end
          n.cw_up[ch] = nxt;
          n.ccr_up    = nxt;
          if (nxt == s.ccr_lo) begin
            n.active[ch] = 1'b0;
          end
          n.svc = 1'b0;
          n.st  = ST_IDLE;
        end
      end
      ST_BM: begin
        if (MEM_ACK) begin
          n.mem.req  = 1'b0;
          n.st       = ST_IDLE;
          // count written back per word so a halt leaves what remains
          n.bm_count = s.r;
          n.nz       = (s.r != '0);
          n.r        = s.r - 15'h1;
          n.bm_addr  = s.bm_base + s.r - 15'h1;
          if (s.bm_in) begin
            n.x_res = 1'b1;
            n.inact = (s.r != '0);
            n.bm    = BM_IN_HS;
          end else if (s.x_s2[2]) begin
            // fetched word was never presented, so count it again
            n.bm_count = s.r - 15'h1 + 15'h2;
            n.bm       = BM_OFF;
            n.halted   = 1'b1;
            n.cpu_halt = 1'b0;
          end else begin
            n.x_data = MEM_RDATA;
            n.x_rdy  = 1'b1;
            n.x_got  = 1'b0;
            n.bm     = BM_OUT_HS;
            if (s.r == '0) begin
              n.done     = 1'b1;
              n.cpu_halt = 1'b0;
            end
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // channel 7 handshakes
    unique case (s.bm)
      BM_IN_HS: begin
        // resume stays up until the synced ready is seen low
        if (!s.x_s2[0]) begin
          n.x_res = 1'b0;
          if (s.nz) begin
            n.bm = BM_IN_WAIT;
          end else begin
            n.bm       = BM_OFF;
            n.done     = 1'b1;
            n.cpu_halt = 1'b0;
          end
        end
      end
      BM_OUT_HS: begin
        // next fetch waits for resume to be both seen and removed
        if (s.x_rdy && s.x_s2[1]) begin
          n.x_rdy = 1'b0;
          n.x_got = 1'b1;
        end else if (s.x_got && !s.x_s2[1]) begin
          n.x_got = 1'b0;
          n.bm    = s.nz ? BM_OUT_FETCH : BM_OFF;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      // enum fields take their one-hot idle codes, not all zeros
      s    <= '0;
      s.st <= ST_IDLE;
      s.bm <= BM_OFF;
    end else begin
      s <= n;
    end
  end

  assign PRDATA            = s.prdata;
  assign PREADY            = s.pready;
  assign PSLVERR           = s.pslverr;
  assign MEM               = s.mem;
  assign STORAGE_BUSY      = s.busy;
  assign IN_RESUME         = s.in_res;
  assign OUT_READY         = s.wait_f;
  assign OUT_DATA          = s.out_data;
  assign XIN_RESUME        = s.x_res;
  assign XOUT_READY        = s.x_rdy;
  assign XOUT_DATA         = s.x_data;
  assign CPU_HALT          = s.cpu_halt;
  assign INPUT_MOVE_ACTIVE = s.inact;
endmodule

//--- verification/cwb_asserts.sv
// concurrent checks on the ports of the channel word buffer top
module cwb_asserts (
  // clock and reset
  input wire logic                    SYS_CLK,
  input wire logic                    RESET,
  // apb and storage
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PWRITE,
  input wire logic [11:0]             PADDR,
  input wire logic [31:0]             PWDATA,
  input wire cwb_pkg::cwb_mem_t       MEM,
  input wire logic                    MEM_ACK,
  input wire logic                    STORAGE_BUSY,
  // channels
  input wire logic [cwb_pkg::NCH-1:0] OUT_READY,
  input wire logic [cwb_pkg::NCH-1:0] OUT_RESUME,
  input wire logic                    XIN_READY,
  input wire cwb_pkg::cwb_word_t      XIN_DATA,
  input wire logic                    XIN_RESUME,
  input wire logic                    XOUT_READY,
  input wire logic                    XOUT_RESUME,
  input wire logic                    CPU_HALT
);
  timeunit 1ns;
  timeprecision 1ns;
  import cwb_pkg::*;
  logic cmd_wr;
  // a legal block move command on the bus
  assign cmd_wr = PSEL && PENABLE && PWRITE && PADDR == REG_BM_CMD &&
                  (PWDATA[5:0] == OP_MOVE_IN || PWDATA[5:0] == OP_MOVE_OUT);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  chk_ready_after_ack: assert property ($rose(OUT_READY[0]) |-> $past(MEM_ACK))
    else $error("output ready rose without a storage completion");
  chk_ready_drop: assert property (OUT_READY[0] && OUT_RESUME[0] |-> ##[1:5] !OUT_READY[0])
    else $error("output ready held after resume");
  chk_next_word: assert property ($rose(OUT_READY[0]) |-> !$past(OUT_RESUME[0], 2))
    else $error("next output word before resume fell");
  chk_busy_mark: assert property (MEM.req && !CPU_HALT |-> STORAGE_BUSY)
    else $error("buffer storage access without busy");
  chk_move_start: assert property ($rose(CPU_HALT) |->
      $past(cmd_wr) || $past(cmd_wr, 2) || $past(cmd_wr, 3))
    else $error("block move started without a legal command");
  chk_xin_store: assert property (MEM.req && MEM.we && CPU_HALT && !STORAGE_BUSY
      |-> MEM.wdata == XIN_DATA)
    else $error("block input stored a word other than the line data");
  chk_xres_order: assert property ($fell(XIN_RESUME) |-> !$past(XIN_READY, 3))
    else $error("input resume dropped before synced ready fell");
  chk_xout_drop: assert property (XOUT_READY && XOUT_RESUME |-> ##[1:5] !XOUT_READY)
    else $error("channel 7 output ready held after resume");
endmodule

//--- verification/cwb_periph.sv
// peripheral equipment and core storage model facing the block
module cwb_periph #(
  parameter cwb_pkg::cwb_word_t MW = 48'h0,
  parameter cwb_pkg::cwb_word_t XW = 48'h0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // core storage
  input  wire cwb_pkg::cwb_mem_t mem,
  output cwb_pkg::cwb_word_t    mem_rdata,
  output logic                  mem_ack,
  // buffered channels
  output logic [5:0]            in_ready,
  output logic [5:0][47:0]      in_data,
  input  wire logic [5:0]       in_resume,
  input  wire logic [5:0]       out_ready,
  output logic [5:0]            out_resume,
  // channel 7
  output logic                  xin_ready,
  output cwb_pkg::cwb_word_t    xin_data,
  input  wire logic             xin_resume,
  input  wire logic             xout_ready,
  output logic                  xout_resume
);
  timeunit 1ns;
  timeprecision 1ns;
  import cwb_pkg::*;
  cwb_word_t       core [64];
  logic [5:0][3:0] od;
  logic [5:0][7:0] iseq;
  logic [5:0]      tog;
  logic [7:0]      xseq;
  logic [3:0]      xd;

  initial for (int i = 0; i < 64; i++) core[i] = MW | 48'(i);
  // storage data shows only while the access completes
  assign mem_rdata = mem_ack ? core[mem.addr[5:0]] : ~core[mem.addr[5:0]];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      in_ready <= '0;
      in_data <= '0;
      out_resume <= '0;
      xin_ready <= 1'b0;
      xin_data <= '0;
      xout_resume <= 1'b0;
      od <= '0;
      iseq <= '0;
      tog <= '0;
      xseq <= '0;
      xd <= '0;
    end else begin
      mem_ack <= mem.req && !mem_ack;
      if (mem_ack && mem.we) begin
        core[mem.addr[5:0]] <= mem.wdata;
      end
      for (int i = 0; i < 6; i++) begin
        // word offered ahead of service, released once resumed
        if (in_ready[i] && in_resume[i]) begin
          in_ready[i] <= 1'b0;
          in_data[i] <= ~in_data[i];
          iseq[i] <= iseq[i] + 8'h01;
        end else if (!in_ready[i] && !in_resume[i]) begin
          in_ready[i] <= 1'b1;
          in_data[i] <= XW | 48'(iseq[i]);
        end
        // word taken after a short or long pause, resume dropped after ready
        if (!out_ready[i]) begin
          out_resume[i] <= 1'b0;
          od[i] <= 4'h0;
        end else if (od[i] == (tog[i] ? 4'h6 : 4'h1) && !out_resume[i]) begin
          out_resume[i] <= 1'b1;
          tog[i] <= ~tog[i];
        end else if (!out_resume[i]) begin
          od[i] <= od[i] + 4'h1;
        end
      end
      // channel 7 input words numbered in order of acceptance
      if (xin_ready && xin_resume) begin
        xin_ready <= 1'b0;
        xin_data <= ~xin_data;
        xseq <= xseq + 8'h01;
      end else if (!xin_ready && !xin_resume) begin
        xin_ready <= 1'b1;
        xin_data <= XW | 48'(xseq);
      end
      // channel 7 output taken slowly, resume removed after ready falls
      if (!xout_ready) begin
        xout_resume <= 1'b0;
        xd <= 4'h0;
      end else if (xd == 4'h4) begin
        xout_resume <= 1'b1;
      end else begin
        xd <= xd + 4'h1;
      end
    end
  end
endmodule

//--- verification/testbench.sv
// self-checking bench for the channel word buffer and block move
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cwb_pkg::*;
  localparam cwb_word_t MW = 48'hc0de_0000_0000;
  localparam cwb_word_t XW = 48'h5a5a_0000_0000;
  typedef struct {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } cwb_row_t;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic INT_REQ = 1'b0;
  logic po = 1'b0;
  logic px = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, rv;
  logic PREADY, PSLVERR, MEM_ACK, STORAGE_BUSY, re, XIN_READY, XIN_RESUME;
  logic XOUT_RESUME, XOUT_READY, CPU_HALT, INPUT_MOVE_ACTIVE;
  cwb_mem_t MEM;
  cwb_word_t MEM_RDATA, XIN_DATA, XOUT_DATA;
  logic [NCH-1:0] IN_READY, IN_RESUME, OUT_RESUME, OUT_READY;
  logic [NCH-1:0][DW-1:0] IN_DATA, OUT_DATA;
  cwb_word_t oq[$], xq[$];
  logic [62:0] wq[$];
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  cwb_row_t rows[8] = '{'{0, REG_CTRL, 0, 0, 0}, '{0, REG_STAT, 0, 0, 0},
    '{0, REG_CW_BASE + 12'h014, 0, 0, 0}, '{1, REG_BM_CMD, 32'h3f, 0, 0},
    '{0, REG_STAT, 0, 0, 0}, '{1, REG_BM_BASE, 32'hffff_ffff, 0, 0},
    '{0, REG_BM_BASE, 0, 32'h7fff, 0}, '{0, 12'hffc, 0, 0, 1}};

  cwb_top cwb_top_inst (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .MEM, .MEM_RDATA, .MEM_ACK, .STORAGE_BUSY, .IN_READY, .IN_DATA,
    .IN_RESUME, .OUT_RESUME, .OUT_READY, .OUT_DATA, .XIN_READY, .XIN_DATA, .XIN_RESUME,
    .XOUT_RESUME, .XOUT_READY, .XOUT_DATA, .INT_REQ, .CPU_HALT, .INPUT_MOVE_ACTIVE);
  cwb_periph #(.MW(MW), .XW(XW)) cwb_periph_inst (.clk(SYS_CLK), .rst(RESET), .mem(MEM),
    .mem_rdata(MEM_RDATA), .mem_ack(MEM_ACK), .in_ready(IN_READY), .in_data(IN_DATA),
    .in_resume(IN_RESUME), .out_ready(OUT_READY), .out_resume(OUT_RESUME),
    .xin_ready(XIN_READY), .xin_data(XIN_DATA), .xin_resume(XIN_RESUME),
    .xout_ready(XOUT_READY), .xout_resume(XOUT_RESUME));

  always #5 SYS_CLK = ~SYS_CLK;

  // words presented on the lines and words written to storage
  always @(negedge SYS_CLK) begin
    if (OUT_READY[0] && !po) oq.push_back(OUT_DATA[0]);
    if (XOUT_READY && !px) xq.push_back(XOUT_DATA);
    if (MEM_ACK && MEM.we) wq.push_back({MEM.addr, MEM.wdata});
    po = OUT_READY[0];
    px = XOUT_READY;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // values read just after an edge are those that edge sampled
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, re);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rv, re);
    chk(rv, exp);
  endtask

  task automatic bm(input logic [14:0] b, input logic [14:0] n, input logic [5:0] op,
                    input int k);
    wr(REG_BM_BASE, {17'h0, b});
    wr(REG_BM_COUNT, {17'h0, n});
    wq.delete();
    xq.delete();
    wr(REG_BM_CMD, {26'h0, op});
    // k above zero raises the halt request once k output words were shown
    for (int i = 0; i < 200 && k > 0 && xq.size() < k; i++) @(posedge SYS_CLK);
    if (k > 0) INT_REQ <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    // wait out the last handshake too, so the next command is taken
    for (int i = 0; i < 500 && (CPU_HALT || XOUT_READY || XOUT_RESUME || XIN_RESUME) !== 1'b0;
         i++) @(posedge SYS_CLK);
    repeat (4) @(posedge SYS_CLK);
  endtask

  initial begin
    repeat (8) @(posedge SYS_CLK);
    RESET <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rv, re);
      if (!rows[i].w) chk(rv, rows[i].r);
      chk(re, rows[i].e);
    end
    // channel 1 output buffer across control word slots 4 to 6 and plain word 7
    wr(REG_CW_BASE, 32'h0004_0008);
    wr(REG_CTRL, 32'h0000_0101);
    for (int i = 0; i < 600 && oq.size() < 5; i++) @(posedge SYS_CLK);
    chk(oq.size(), 4);
    for (int i = 0; i < 3; i++) chk(oq[i], MW & ~48'h007f_ff00_7fff);
    chk(oq[3], MW | 48'h7);
    rd(REG_CTRL, 32'h0000_0100);
    rd(REG_CW_BASE, 32'h0008_0008);
    rd(REG_STAT, 32'h0002_0000);
    // channel 2 input buffer into control word slots 3 and 4
    wr(REG_CW_BASE + 12'h004, 32'h0003_0005);
    wr(REG_CTRL, 32'h0000_0102);
    for (int i = 0; i < 300 && wq.size() < 3; i++) @(posedge SYS_CLK);
    chk(wq.size(), 2);
    chk(wq[0], {15'h3, XW});
    chk(wq[1], {15'h4, XW | 48'h1});
    rd(REG_CW_BASE + 12'h008, 32'h5a00_0000);
    rd(REG_CTRL, 32'h0000_0100);
    // block input of two words lands at descending addresses
    bm(15'h20, 15'h2, OP_MOVE_IN, 0);
    chk(wq.size(), 2);
    chk(wq[0], {15'h21, XW});
    chk(wq[1], {15'h20, XW | 48'h1});
    rd(REG_BM_COUNT, 32'h0);
    chk(INPUT_MOVE_ACTIVE, 1'b0);
    bm(15'h30, 15'h3, OP_MOVE_OUT, 0);
    for (int i = 0; i < 200 && xq.size() < 3; i++) @(posedge SYS_CLK);
    for (int i = 0; i < 3; i++) chk(xq[i], MW | (48'h32 - 48'(i)));
    // interrupt pending: input stops at the first ready and keeps its count
    INT_REQ <= 1'b1;
    bm(15'h20, 15'h2, OP_MOVE_IN, 0);
    chk(wq.size(), 0);
    rd(REG_BM_COUNT, 32'h2);
    apb(1'b0, REG_STAT, 32'h0, rv, re);
    chk(rv[STAT_HALTED], 1'b1);
    // interrupt after the first output word: two words remain
    INT_REQ <= 1'b0;
    bm(15'h30, 15'h3, OP_MOVE_OUT, 1);
    chk(xq.size(), 1);
    chk(xq[0], MW | 48'h32);
    rd(REG_BM_COUNT, 32'h2);
    INT_REQ <= 1'b0;
    summarize();
  end
endmodule

bind cwb_top cwb_asserts cwb_asserts_inst (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .MEM, .MEM_ACK, .STORAGE_BUSY, .OUT_READY, .OUT_RESUME, .XIN_READY, .XIN_DATA,
  .XIN_RESUME, .XOUT_READY, .XOUT_RESUME, .CPU_HALT);
